/* File: verification/eipc_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module eipc_core_model (
    // Clock
    input wire logic clk_sys,
    // Register access toward the block
    output var eipc_pkg::eipc_sfr_req_s sfr_req
);
    // Expected {hit, data} of each read, oldest first
    logic [8:0] exp_q[$];

    initial sfr_req = '0;

    // One access held for exactly one taking edge; afterwards the bus
    // shows the inverse so a stale address or byte cannot pass
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [8:0] x);
        if (!w) exp_q.push_back(x);
        @(posedge clk_sys);
        #2 sfr_req = '{addr: a, wdata: x[7:0], wr: w, rd: !w};
        @(posedge clk_sys);
        #2 sfr_req = '{addr: ~a, wdata: ~x[7:0], wr: 1'b0, rd: 1'b0};
    endtask
endmodule
`default_nettype wire

/* File: verification/eipc_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module eipc_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register bus
    input wire eipc_pkg::eipc_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rd_hit,
    // Results
    input wire logic serial1_baud_double,
    input wire eipc_pkg::eipc_grant_s irq_grant
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // Decode of the current request, sampled at the taking edge
    wire logic [7:0] a = sfr_req.addr;
    wire logic rd = sfr_req.rd;
    wire logic wr = sfr_req.wr;
    wire logic hit = a == 8'h91 || a == 8'hb8 || a == 8'hd8 ||
        a == 8'he8 || a == 8'hf8;

    // Read answers and fixed bits
    chk_map_hit: assert property (rd && hit |=> sfr_rd_hit)
        else $error("mapped read gave no hit");
    chk_unmapped_zero: assert property (rd && !hit |=>
        !sfr_rd_hit && sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_hit_pulse: assert property (!rd |=> !sfr_rd_hit)
        else $error("hit without read");
    chk_flag_rsv: assert property (rd && a == 8'h91 |=>
        sfr_rdata[3:0] == 4'h8)
        else $error("flag register fixed bits wrong");
    chk_wake_rsv: assert property (rd && a == 8'hd8 |=>
        sfr_rdata[6] && sfr_rdata[2:0] == 3'h0 &&
        sfr_rdata[7] == serial1_baud_double)
        else $error("wake register fixed bits wrong");
    chk_ext_rsv: assert property (rd && (a == 8'he8 || a == 8'hf8)
        |=> sfr_rdata[7:5] == 3'h7)
        else $error("extended register upper bits wrong");
    // A written priority byte must come back on a read two cycles after the write
    chk_prio_back: assert property (wr && a == 8'hb8 ##1 !wr
        ##1 rd && a == 8'hb8 |=> sfr_rdata == {1'b1,
        $past(sfr_req.wdata[6:0], 3)})
        else $error("priority readback wrong");
    // Baud doubler follows only writes of the control register
    chk_baud_write: assert property (wr && a == 8'hd8 |=>
        serial1_baud_double == $past(sfr_req.wdata[7]))
        else $error("baud doubler not written");
    chk_baud_hold: assert property (!(wr && a == 8'hd8) |=>
        $stable(serial1_baud_double))
        else $error("baud doubler changed");
    // Top level belongs to the resume source alone
    chk_top_resume: assert property (irq_grant.level == 2'h2 |->
        irq_grant.valid && irq_grant.source == 4'h0)
        else $error("top level not resume");
    chk_resume_top: assert property (irq_grant.valid &&
        irq_grant.source == 4'h0 |-> irq_grant.level == 2'h2)
        else $error("resume below top level");

    // Main scenarios
    cov_top: cover property (irq_grant.valid && irq_grant.level == 2'h2);
    cov_high: cover property (irq_grant.valid && irq_grant.level == 2'h1);
    cov_unmapped: cover property (rd && !hit);
endmodule
bind eipc_top eipc_monitor mon (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_rd_hit(sfr_rd_hit),
    .serial1_baud_double(serial1_baud_double), .irq_grant(irq_grant)
);
`default_nettype wire

/* File: verification/eipc_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module eipc_top_tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    eipc_pkg::eipc_sfr_req_s sfr_req;
    logic [7:0] sfr_rdata;
    logic sfr_rd_hit;
    logic serial1_baud_double;
    eipc_pkg::eipc_grant_s irq_grant;
    logic [6:0] p = 7'h00;
    logic [7:0] s = 8'h00;
    logic [6:0] std_en = 7'h00;
    logic gen = 1'b0;
    logic [7:0] d, a, m, b;
    int n_errors = 0;
    int samples_checked = 0;
    int i, k;
    int pos [7] = '{6, 7, 5, 4, 3, 4, 4};

    // Clock
    always #20 clk_sys = ~clk_sys;

    eipc_core_model core (.clk_sys(clk_sys), .sfr_req(sfr_req));
    // Event pins: p is the active sense, inverted for low-true pins
    eipc_top dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .sfr_rd_hit(sfr_rd_hit),
        .ext4_rise_pin(p[0]), .ext5_fall_pin_n(~p[1]), .ext6_rise_pin(p[4]),
        .wake_pin_n(~p[5]), .twowire_irq_req(p[2]), .usb_irq_req(p[3]),
        .usb_resume_evt(p[6]), .ext_zero_input(s[0]), .timer0_overflow(s[1]),
        .ext_one_input(s[2]), .timer1_overflow(s[3]), .serial0_req(s[4]),
        .timer2_overflow(s[5]), .serial1_tx_done(s[6]),
        .serial1_rx_done(s[7]), .std_irq_en(std_en), .global_irq_en(gen),
        .serial1_baud_double(serial1_baud_double), .irq_grant(irq_grant)
    );

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic w(input logic [7:0] ad, input logic [7:0] dd);
        core.acc(1'b1, ad, {1'b0, dd});
    endtask
    task automatic r(input logic [7:0] ad, input logic [8:0] e);
        core.acc(1'b0, ad, e);
    endtask
    // Grant settles one edge after its cause; two edges leave margin
    task automatic g(input logic v, input logic [1:0] l, input logic [3:0] sr);
        repeat (2) @(posedge clk_sys);
        #2 cmp(irq_grant, {v, l, sr});
    endtask
    task end_sim;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Read watcher: pops the oldest note once the answer has landed
    always @(posedge clk_sys) begin
        if (sfr_req.rd === 1'b1) begin
            #1 cmp({sfr_rd_hit, sfr_rdata}, core.exp_q.pop_front());
        end
    end

    // Watchdog well past the expected run length
    initial begin
        #(40 * 6000);
        n_errors++;
        $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end_sim;
    end

    initial begin
        void'($urandom(32'h0c2f));
        repeat (6) @(posedge clk_sys);
        #2 sys_rst = 1'b0;
        r(8'h91, 9'h108);
        r(8'hb8, 9'h180);
        r(8'hd8, 9'h140);
        r(8'he8, 9'h1e0);
        r(8'hf8, 9'h1e0);
        w(8'h90, 8'hff);
        r(8'h90, 9'h000);
        $display("test reset values done");
        for (i = 0; i < 8; i++) begin
            d = 8'($urandom);
            w(8'hb8, d);
            r(8'hb8, {1'b1, d | 8'h80});
            w(8'he8, d);
            r(8'he8, {1'b1, d | 8'he0});
            w(8'hf8, d);
            r(8'hf8, {1'b1, d | 8'he0});
            w(8'h91, d & 8'hf0);
            r(8'h91, {1'b1, (d & 8'hf0) | 8'h08});
            w(8'hd8, d & 8'ha0);
            cmp(serial1_baud_double, d[7]);
            r(8'hd8, {1'b1, (d & 8'ha0) | 8'h40});
        end
        w(8'hb8, 8'h00);
        w(8'he8, 8'h00);
        w(8'hf8, 8'h00);
        w(8'hd8, 8'h00);
        w(8'h91, 8'h00);
        $display("test readback done");
        // Level-held requests other than USB resume, which is pulsed for one cycle, do not set their flag again after the clear
        for (k = 0; k < 7; k++) begin
            a = (k < 4) ? 8'h91 : 8'hd8;
            b = (k < 4) ? 8'h08 : 8'h40;
            m = 8'h01 << pos[k];
            @(posedge clk_sys);
            #2 p[k] = 1'b1;
            if (k == 6) begin
                @(posedge clk_sys);
                #2 p[k] = 1'b0;
            end
            r(a, {1'b1, b | m});
            w(a, 8'h00);
            r(a, {1'b1, b});
            p[k] = 1'b0;
        end
        fork
            w(8'h91, 8'h00);
            begin
                @(posedge clk_sys);
                #2 p[0] = 1'b1;
            end
        join
        r(8'h91, 9'h148);
        p[0] = 1'b0;
        w(8'h91, 8'h00);
        $display("test hardware events done");
        gen = 1'b1;
        for (k = 0; k < 5; k++) begin
            a = (k < 4) ? 8'h91 : 8'hd8;
            m = (k < 4) ? 8'h10 << k : 8'h08;
            w(8'he8, 8'h01 << k);
            w(a, m);
            g(1'b1, eipc_pkg::LVL_LOW, 4'(8 + k));
            w(8'hf8, 8'h01 << k);
            g(1'b1, eipc_pkg::LVL_HIGH, 4'(8 + k));
            w(8'he8, 8'h00);
            g(1'b0, 2'h0, 4'h0);
            w(a, 8'h00);
            w(8'hf8, 8'h00);
        end
        $display("test extended sources done");
        std_en = 7'h7f;
        for (k = 0; k < 7; k++) begin
            s = (k == 6) ? 8'hbf : 8'hff;
            w(8'hb8, 8'h01 << k);
            g(1'b1, eipc_pkg::LVL_HIGH, 4'(k + 1));
        end
        w(8'hb8, 8'h00);
        g(1'b1, eipc_pkg::LVL_LOW, 4'h1);
        $display("test standard sources done");
        gen = 1'b0;
        w(8'hd8, 8'h30);
        g(1'b1, eipc_pkg::LVL_TOP, 4'h0);
        gen = 1'b1;
        w(8'hb8, 8'h7f);
        g(1'b1, eipc_pkg::LVL_TOP, 4'h0);
        w(8'hd8, 8'h10);
        g(1'b1, eipc_pkg::LVL_HIGH, 4'h1);
        s = 8'h00;
        w(8'hd8, 8'h00);
        g(1'b0, 2'h0, 4'h0);
        $display("test resume done");
        end_sim;
    end
endmodule
`default_nettype wire

/* File: verilog/eipc_edge_det.sv */
`timescale 1ns/1ns
`default_nettype none
module eipc_edge_det #(
    parameter bit RISE = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Sampled level and detected edge
    input wire logic sig,
    output logic edge_pulse
);
    logic prev;
    logic armed;

    // Armed one cycle after reset so a pin already at its
    // active level is not mistaken for an edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prev <= 1'b0;
            armed <= 1'b0;
        end else begin
            prev <= sig;
            armed <= 1'b1;
        end
    end

    // One-cycle pulse on the chosen transition
    assign edge_pulse = armed & (RISE ? (sig & ~prev) : (~sig & prev));
endmodule
`default_nettype wire

/* File: verilog/eipc_pkg.sv */
package eipc_pkg;

    // Register addresses in the special function register space
    localparam logic [7:0] ADDR_FLAGS = 8'h91;
    localparam logic [7:0] ADDR_PRIO_BASE = 8'hb8;
    localparam logic [7:0] ADDR_WAKE = 8'hd8;
    localparam logic [7:0] ADDR_EN = 8'he8;
    localparam logic [7:0] ADDR_PRIO_EXT = 8'hf8;

    // Bit positions in the extended flag register
    localparam int FLG_EXT5 = 7;
    localparam int FLG_EXT4 = 6;
    localparam int FLG_TW = 5;
    localparam int FLG_USB = 4;

    // Bit positions in the wakeup and baud control register
    localparam int WK_BAUD = 7;
    localparam int WK_EN = 5;
    localparam int WK_FLAG = 4;
    localparam int WK_EXT6 = 3;

    // Bits that always read as one
    localparam logic [7:0] RSV1_PRIO_BASE = 8'h80;
    localparam logic [7:0] RSV1_FLAGS = 8'h08;
    localparam logic [7:0] RSV1_WAKE = 8'h40;
    localparam logic [7:0] RSV1_EXT = 8'he0;

    // Values after reset
    localparam logic [6:0] RST_PRIO_BASE = 7'h00;
    localparam logic [4:0] RST_PRIO_EXT = 5'h00;
    localparam logic [4:0] RST_EN = 5'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic RST_BIT = 1'b0;

    // Sources in natural priority order, index 0 wins
    localparam int NUM_SRC = 13;
    localparam int SRC_W = 4;
    localparam int SRC_RESUME = 0;
    localparam int SRC_STD_LO = 1;
    localparam int SRC_USB = 8;
    localparam int SRC_TW = 9;
    localparam int SRC_EXT4 = 10;
    localparam int SRC_EXT5 = 11;
    localparam int SRC_EXT6 = 12;

    // Interrupt levels
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;
    localparam logic [1:0] LVL_TOP = 2'h2;

    // One register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } eipc_sfr_req_s;

    // Winning request
    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [3:0] source;
    } eipc_grant_s;

endpackage

/* File: verilog/eipc_prio_arb.sv */
`timescale 1ns/1ns
`default_nettype none
module eipc_prio_arb #(
    parameter int N = 13
) (
    // Pending requests, index 0 is the resume source
    input wire logic [N-1:0] pend,
    input wire logic [N-1:0] is_high,
    // Winner
    output eipc_pkg::eipc_grant_s grant
);
    // Lowest set index, with a found bit on top
    function automatic logic [4:0] first_set(input logic [N-1:0] vec);
        logic [4:0] res;
        res = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (vec[i]) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction

    logic [N-1:0] others;
    logic [4:0] high_pick;
    logic [4:0] low_pick;

    // Resume is kept out of the two ordinary levels
    assign others = pend & ~N'(1);
    assign high_pick = first_set(others & is_high);
    assign low_pick = first_set(others & ~is_high);

    // Level first, natural order second
    always_comb begin
        grant = '0;
        if (pend[eipc_pkg::SRC_RESUME]) begin
            grant = {1'b1, eipc_pkg::LVL_TOP, 4'h0};
        end else if (high_pick[4]) begin
            grant = {1'b1, eipc_pkg::LVL_HIGH, high_pick[3:0]};
        end else if (low_pick[4]) begin
            grant = {1'b1, eipc_pkg::LVL_LOW, low_pick[3:0]};
        end
    end
endmodule
`default_nettype wire

/* File: verilog/eipc_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Base priority bits per standard source, 1 high
// - Extended priority bits for inputs four to six, two-wire and USB
// - Extended enable bits gate the five sources
// - Falling edge on input five sets flag
// - Rising edge on input four sets flag
// - Two-wire controller request sets its flag
// - USB interrupt request sets its flag
// - Flags stay set; writing one raises interrupt
// - Control bit seven doubles serial one baud
// - Wake pin fall or USB resume sets flag
// - Uncleared wake flag keeps requesting; writable too
// - Rising edge on input six sets flag
// - Input six flag held until written zero
// - Reserved bits read back fixed ones, zeros
// - Enabled resume always wins at top level
// - Equal levels resolved by natural order
module eipc_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register access from the core
    input wire eipc_pkg::eipc_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_rd_hit,
    // External pins, synchronous to the clock
    input wire logic ext4_rise_pin,
    input wire logic ext5_fall_pin_n,
    input wire logic ext6_rise_pin,
    input wire logic wake_pin_n,
    // On-chip interrupt requests
    input wire logic twowire_irq_req,
    input wire logic usb_irq_req,
    input wire logic usb_resume_evt,
    // Standard sources and their enables
    input wire logic ext_zero_input,
    input wire logic timer0_overflow,
    input wire logic ext_one_input,
    input wire logic timer1_overflow,
    input wire logic serial0_req,
    input wire logic timer2_overflow,
    input wire logic serial1_tx_done,
    input wire logic serial1_rx_done,
    input wire logic [6:0] std_irq_en,
    input wire logic global_irq_en,
    // Results
    output logic serial1_baud_double,
    output var eipc_pkg::eipc_grant_s irq_grant
);
    // Stored register bits
    logic [6:0] prio_base;
    logic [4:0] ext_prio;
    logic [4:0] ext_en;
    logic ext5_edge_flag;
    logic ext4_edge_flag;
    logic twowire_irq_flag;
    logic usb_irq_flag;
    logic wake_irq_en;
    logic wake_flag;
    logic ext6_event_flag;

    // Next values of the flags
    logic next_ext5_edge_flag;
    logic next_ext4_edge_flag;
    logic next_twowire_irq_flag;
    logic next_usb_irq_flag;
    logic next_wake_flag;
    logic next_ext6_event_flag;

    // Edge pulses
    logic ext4_rise;
    logic ext5_fall;
    logic ext6_rise;
    logic wake_fall;
    logic twowire_rise;
    logic usb_rise;

    // Register decode
    wire sel_flags = sfr_req.addr == eipc_pkg::ADDR_FLAGS;
    wire sel_prio_base = sfr_req.addr == eipc_pkg::ADDR_PRIO_BASE;
    wire sel_wake = sfr_req.addr == eipc_pkg::ADDR_WAKE;
    wire sel_en = sfr_req.addr == eipc_pkg::ADDR_EN;
    wire sel_prio_ext = sfr_req.addr == eipc_pkg::ADDR_PRIO_EXT;
    wire sel_any = sel_flags | sel_prio_base | sel_wake | sel_en
        | sel_prio_ext;

    // Write strobes per register
    wire wr_flags = sfr_req.wr & sel_flags;
    wire wr_prio_base = sfr_req.wr & sel_prio_base;
    wire wr_wake = sfr_req.wr & sel_wake;
    wire wr_en = sfr_req.wr & sel_en;
    wire wr_prio_ext = sfr_req.wr & sel_prio_ext;
    wire [7:0] wd = sfr_req.wdata;

    // Next value of a software-clearable flag: a hardware event wins
    // over a same-cycle write of zero, so no edge is ever lost
    function automatic logic flag_next(input logic set, input logic wr,
        input logic wbit, input logic cur);
        return set | (wr ? wbit : cur);
    endfunction

    // Edge detectors on the pins; a pin already at its active level
    // when reset ends is not taken as an edge, software must poll it
    eipc_edge_det #(.RISE(1'b1)) u_ext4 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sig(ext4_rise_pin),
        .edge_pulse(ext4_rise)
    );
    eipc_edge_det #(.RISE(1'b0)) u_ext5 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sig(ext5_fall_pin_n),
        .edge_pulse(ext5_fall)
    );
    eipc_edge_det #(.RISE(1'b1)) u_ext6 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sig(ext6_rise_pin),
        .edge_pulse(ext6_rise)
    );
    eipc_edge_det #(.RISE(1'b0)) u_wake (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sig(wake_pin_n),
        .edge_pulse(wake_fall)
    );

    // The two-wire and USB interrupt requests are edge sensitive as well, so a request
    // left high after its flag is cleared does not set it again
    eipc_edge_det #(.RISE(1'b1)) u_twowire (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sig(twowire_irq_req),
        .edge_pulse(twowire_rise)
    );
    eipc_edge_det #(.RISE(1'b1)) u_usb (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sig(usb_irq_req),
        .edge_pulse(usb_rise)
    );

    // Flag updates: a hardware set overrides a write of zero, and a
    // write of one sets the flag just as an event would; a whole-byte
    // write therefore also clears every flag written as zero
    assign next_ext5_edge_flag = flag_next(ext5_fall, wr_flags,
        wd[eipc_pkg::FLG_EXT5], ext5_edge_flag);
    assign next_ext4_edge_flag = flag_next(ext4_rise, wr_flags,
        wd[eipc_pkg::FLG_EXT4], ext4_edge_flag);
    assign next_twowire_irq_flag = flag_next(twowire_rise,
        wr_flags, wd[eipc_pkg::FLG_TW], twowire_irq_flag);
    assign next_usb_irq_flag = flag_next(usb_rise, wr_flags,
        wd[eipc_pkg::FLG_USB], usb_irq_flag);

    // Wake flag: pin fall or USB resume; stays set until written zero
    assign next_wake_flag = flag_next(wake_fall | usb_resume_evt,
        wr_wake, wd[eipc_pkg::WK_FLAG], wake_flag);

    // Input six flag
    assign next_ext6_event_flag = flag_next(ext6_rise,
        wr_wake, wd[eipc_pkg::WK_EXT6], ext6_event_flag);

    // Extended flag register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext5_edge_flag <= eipc_pkg::RST_FLAGS[3];
            ext4_edge_flag <= eipc_pkg::RST_FLAGS[2];
            twowire_irq_flag <= eipc_pkg::RST_FLAGS[1];
            usb_irq_flag <= eipc_pkg::RST_FLAGS[0];
        end else begin
            ext5_edge_flag <= next_ext5_edge_flag;
            ext4_edge_flag <= next_ext4_edge_flag;
            twowire_irq_flag <= next_twowire_irq_flag;
            usb_irq_flag <= next_usb_irq_flag;
        end
    end

    // Wakeup and baud control register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            serial1_baud_double <= eipc_pkg::RST_BIT;
            wake_irq_en <= eipc_pkg::RST_BIT;
            wake_flag <= eipc_pkg::RST_BIT;
            ext6_event_flag <= eipc_pkg::RST_BIT;
        end else begin
            if (wr_wake) begin
                serial1_baud_double <= wd[eipc_pkg::WK_BAUD];
                wake_irq_en <= wd[eipc_pkg::WK_EN];
            end
            wake_flag <= next_wake_flag;
            ext6_event_flag <= next_ext6_event_flag;
        end
    end

    // Base priority register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prio_base <= eipc_pkg::RST_PRIO_BASE;
        end else if (wr_prio_base) begin
            prio_base <= wd[6:0];
        end
    end

    // Extended enable register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_en <= eipc_pkg::RST_EN;
        end else if (wr_en) begin
            ext_en <= wd[4:0];
        end
    end

    // Extended priority register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_prio <= eipc_pkg::RST_PRIO_EXT;
        end else if (wr_prio_ext) begin
            ext_prio <= wd[4:0];
        end
    end

    // Named views of the stored bits; the arbitration below reads
    // them by source so a slip in bit order shows up by name
    logic serial1_prio;
    logic timer2_prio;
    logic serial0_prio;
    logic timer1_prio;
    logic ext1_prio;
    logic timer0_prio;
    logic ext0_prio;
    logic ext6_prio;
    logic ext5_prio;
    logic ext4_prio;
    logic twowire_prio;
    logic usb_irq_prio;
    logic ext6_irq_en;
    logic ext5_irq_en;
    logic ext4_irq_en;
    logic twowire_irq_en;
    logic usb_irq_en;
    assign {serial1_prio, timer2_prio, serial0_prio, timer1_prio,
        ext1_prio, timer0_prio, ext0_prio} = prio_base;
    assign {ext6_prio, ext5_prio, ext4_prio, twowire_prio,
        usb_irq_prio} = ext_prio;
    assign {ext6_irq_en, ext5_irq_en, ext4_irq_en, twowire_irq_en,
        usb_irq_en} = ext_en;

    // Read values with reserved bits forced
    wire [7:0] rd_flags = {ext5_edge_flag, ext4_edge_flag,
        twowire_irq_flag, usb_irq_flag, 4'h0}
        | eipc_pkg::RSV1_FLAGS;
    wire [7:0] rd_prio_base = {1'b0, prio_base}
        | eipc_pkg::RSV1_PRIO_BASE;
    wire [7:0] rd_wake = {serial1_baud_double, 1'b0, wake_irq_en,
        wake_flag, ext6_event_flag, 3'h0}
        | eipc_pkg::RSV1_WAKE;
    wire [7:0] rd_en = {3'h0, ext_en} | eipc_pkg::RSV1_EXT;
    wire [7:0] rd_prio_ext = {3'h0, ext_prio}
        | eipc_pkg::RSV1_EXT;

    // Read multiplexer; unmapped addresses read as zero so that the
    // core can OR this byte with its other register banks
    wire [7:0] rd_mux = sel_flags ? rd_flags
        : sel_prio_base ? rd_prio_base
        : sel_wake ? rd_wake
        : sel_en ? rd_en
        : sel_prio_ext ? rd_prio_ext
        : 8'h00;

    // Read data is held until the next read so the core may sample it
    // late; the hit pulse lets the core's other register muxes step aside
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
            sfr_rd_hit <= 1'b0;
        end else begin
            if (sfr_req.rd) begin
                sfr_rdata <= rd_mux;
            end
            sfr_rd_hit <= sfr_req.rd & sel_any;
        end
    end

    // Raw requests of the standard sources in natural order
    wire [6:0] std_req = {
        serial1_tx_done | serial1_rx_done,
        timer2_overflow,
        serial0_req,
        timer1_overflow,
        ext_one_input,
        timer0_overflow,
        ext_zero_input};

    // Extended requests: flags gated by their enables
    wire [4:0] ext_pend = {
        ext6_event_flag & ext6_irq_en,
        ext5_edge_flag & ext5_irq_en,
        ext4_edge_flag & ext4_irq_en,
        twowire_irq_flag & twowire_irq_en,
        usb_irq_flag & usb_irq_en};

    // The global enable masks all but resume, which only its own
    // enable gates
    wire resume_pend = wake_flag & wake_irq_en;
    wire [6:0] std_pend = std_req & std_irq_en & {7{global_irq_en}};
    wire [4:0] ext_gated = ext_pend & {5{global_irq_en}};

    // Pending and level vectors by source index
    wire [eipc_pkg::NUM_SRC-1:0] pend = {ext_gated, std_pend,
        resume_pend};
    wire [eipc_pkg::NUM_SRC-1:0] is_high = {
        ext6_prio, ext5_prio, ext4_prio, twowire_prio, usb_irq_prio,
        serial1_prio, timer2_prio, serial0_prio, timer1_prio,
        ext1_prio, timer0_prio, ext0_prio,
        1'b0};

    eipc_pkg::eipc_grant_s next_irq_grant;

    eipc_prio_arb #(.N(eipc_pkg::NUM_SRC)) u_arb (
        .pend(pend),
        .is_high(is_high),
        .grant(next_irq_grant)
    );

    // Registered winner; one cycle behind the flags. The extra cycle
    // keeps the arbitration tree off the core's decode path, at the
    // cost of one clock of interrupt latency
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_grant <= '0;
        end else begin
            irq_grant <= next_irq_grant;
        end
    end
endmodule
`default_nettype wire
